// file: core/sfp_core.v
// Command sequencer for page program, deep sleep, secure area and security register.
// Summary of operation
// - Program only clears bits; one to 256 data bytes per command.
// - Program needs the write latch set by a prior write enable.
// - Beyond 256 data bytes only the final 256 are kept.
// - Low address byte is page offset; data wraps to page start.
// - Select must rise on a data byte boundary or program is rejected.
// - Select rise starts timed program; busy set, then latch cleared.
// - Program refused on blocks protected by the active scheme.
// - Opcode uses one line, eight clocks, or four lines in quad mode.
// - Quad program needs latch and quad enable; address and data on four lines.
// - Quad program refused on protected blocks.
// - In deep sleep only wake and software reset are honoured.
// - Deep sleep needs select rise after opcode; entry follows a delay.
// - Software reset or power cycle ends deep sleep; reset gives standby.
// - Secure area mode redirects program to the 4K-bit area.
// - Once locked, secure area updates are refused.
// - Secure exit command returns to main array access.
// - Security register read works except in deep sleep, even while busy, and repeats while clocked.
// - Security register write needs latch and only sets the lock bit.
// - Security register write rejected unless select rises on a boundary.
// - Security register layout: scheme, fails, suspends, lock, factory lock.
// - Program fail set when protection or the secure area lock refuses a program, cleared on success.
`include "sfp_defines.vh"
`default_nettype none
module sfp_core #(
  parameter [19:0] PROG_CYCLES = (`SFP_PROG_TIME_US * 1000) / `SFP_CLK_PERIOD_NS
) (
  input wire core_clk_i,
  input wire resetn_i,
  input wire cs_n_i,
  input wire sclk_i,
  input wire [3:0] sio_i,
  output wire [3:0] sio_o,
  output wire [3:0] sio_oe_o,
  input wire quad_command_mode_i,
  input wire quad_io_enable_i,
  input wire protect_scheme_select_i,
  input wire [3:0] legacy_protect_field_i,
  input wire [255:0] persistent_block_lock_i,
  input wire [255:0] volatile_block_lock_i,
  input wire factory_lock_i,
  input wire erase_fail_i,
  input wire erase_suspended_flag_i,
  input wire program_suspended_flag_i,
  output wire prog_valid_o,
  input wire prog_ready_i,
  output wire prog_otp_o,
  output wire [23:0] prog_addr_o,
  output wire [7:0] prog_data_o,
  output wire write_latch_o,
  output wire write_in_progress_flag_o,
  output wire deep_sleep_o,
  output wire otp_mode_o,
  output wire otp_lock_bit_o,
  output wire program_fail_o
);
  localparam [2:0] ST_OP = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_OUT = 3'h3;
  localparam [2:0] ST_IGN = 3'h4;
  localparam [2:0] ST_DONE = 3'h5;
  localparam SLEEP_CYC =
    (`SFP_SLEEP_DELAY_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS;

  // Legacy scheme protects the top 2^(field-1) blocks; nine or more protects all.
  function legacy_hit;
    input [3:0] field;
    input [7:0] blk;
    reg [8:0] span;
    begin
      span = 9'h001 << (field - 4'h1);
      if (field == 4'h0) begin
        legacy_hit = 1'b0;
      end else if (field >= 4'h9) begin
        legacy_hit = 1'b1;
      end else begin
        legacy_hit = ({1'b0, blk} >= (9'h100 - span));
      end
    end
  endfunction

  wire [5:0] pins_s;
  wire cs_s = pins_s[5];
  wire sclk_s = pins_s[4];
  wire [3:0] sio_s = pins_s[3:0];

  sfp_sync #(
    .W(6),
    .INIT(6'h20)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .d_i({cs_n_i, sclk_i, sio_i}),
    .q_o(pins_s)
  );

  reg cs_d_reg;
  reg sclk_d_reg;
  reg [2:0] state_reg;
  reg [7:0] sh_reg;
  reg [3:0] bit_cnt_reg;
  reg [2:0] byte_cnt_reg;
  reg [7:0] op_reg;
  reg [23:0] addr_reg;
  reg [7:0] ptr_reg;
  reg data_seen_reg;
  reg quad_cmd_reg;
  reg [7:0] out_sh_reg;
  reg out_first_reg;
  reg [7:0] page_buf [0:`SFP_PAGE_BYTES-1];
  reg [255:0] mask_reg;
  reg latch_reg;
  reg busy_reg;
  reg draining_reg;
  reg [8:0] drain_idx_reg;
  reg [15:0] page_base_reg;
  reg prog_otp_reg;
  reg [19:0] prog_cnt_reg;
  reg sleeping_reg;
  reg sleep_pend_reg;
  reg [15:0] sleep_cnt_reg;
  reg otp_mode_reg;
  reg otp_lock_reg;
  reg pfail_reg;

  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire cs_fall = ~cs_s & cs_d_reg;
  wire cs_rise = cs_s & ~cs_d_reg;
  // Opcode width
  // one or four lines
  wire op_wide = quad_command_mode_i;
  wire pay_wide = quad_command_mode_i | quad_cmd_reg;
  wire wide = (state_reg == ST_OP) ? op_wide : pay_wide;
  wire [7:0] sh_next = wide ? {sh_reg[3:0], sio_s} : {sh_reg[6:0], sio_s[0]};
  wire [3:0] cnt_next = bit_cnt_reg + (wide ? 4'h4 : 4'h1);
  wire byte_end = (cnt_next == 4'h8);
  wire sleep_any = sleeping_reg | sleep_pend_reg;
  wire boundary = (bit_cnt_reg == 4'h0);
  wire op_only = boundary && (byte_cnt_reg == 3'h1) && (state_reg == ST_DONE);
  wire [7:0] blk = addr_reg[23:16];
  wire blk_prot = protect_scheme_select_i ?
    (persistent_block_lock_i[blk] | volatile_block_lock_i[blk]) :
    legacy_hit(legacy_protect_field_i, blk);
  wire otp_locked = otp_lock_reg | factory_lock_i;
  wire [7:0] secreg = {protect_scheme_select_i, erase_fail_i, pfail_reg, 1'b0,
    erase_suspended_flag_i, program_suspended_flag_i, otp_lock_reg, factory_lock_i};
  wire [7:0] didx = drain_idx_reg[7:0];
  wire fifo_in_ready;
  wire fifo_in_valid = draining_reg & mask_reg[didx];
  wire drain_step = draining_reg & (~mask_reg[didx] | fifo_in_ready);

  assign sio_oe_o = (state_reg == ST_OUT && !cs_s) ?
    (quad_command_mode_i ? 4'hF : 4'h2) : 4'h0;
  assign sio_o = quad_command_mode_i ? out_sh_reg[7:4] : {2'h0, out_sh_reg[7], 1'b0};
  assign write_latch_o = latch_reg;
  assign write_in_progress_flag_o = busy_reg;
  assign deep_sleep_o = sleeping_reg;
  assign otp_mode_o = otp_mode_reg;
  assign otp_lock_bit_o = otp_lock_reg;
  assign program_fail_o = pfail_reg;

  // Page buffer write
  // offset wraps in page
  always @(posedge core_clk_i) begin
    if (!cs_s && sclk_rise && state_reg == ST_DATA && byte_end) begin
      page_buf[ptr_reg] <= sh_next;
    end
  end

  sfp_fifo #(
    .W(`SFP_FIFO_WIDTH),
    .DEPTH(`SFP_FIFO_DEPTH),
    .AW(5)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i({prog_otp_reg, page_base_reg, didx, page_buf[didx]}),
    .out_valid_o(prog_valid_o),
    .out_ready_i(prog_ready_i),
    .out_data_o({prog_otp_o, prog_addr_o, prog_data_o})
  );

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
      state_reg <= ST_IGN;
      sh_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      byte_cnt_reg <= 3'h0;
      op_reg <= 8'h00;
      addr_reg <= 24'h000000;
      ptr_reg <= 8'h00;
      data_seen_reg <= 1'b0;
      quad_cmd_reg <= 1'b0;
      out_sh_reg <= 8'h00;
      out_first_reg <= 1'b0;
      mask_reg <= {256{1'b0}};
      latch_reg <= 1'b0;
      busy_reg <= 1'b0;
      draining_reg <= 1'b0;
      drain_idx_reg <= 9'h000;
      page_base_reg <= 16'h0000;
      prog_otp_reg <= 1'b0;
      prog_cnt_reg <= 20'h00000;
      sleeping_reg <= 1'b0;
      sleep_pend_reg <= 1'b0;
      sleep_cnt_reg <= 16'h0000;
      otp_mode_reg <= 1'b0;
      otp_lock_reg <= 1'b0;
      pfail_reg <= 1'b0;
    end else begin
      cs_d_reg <= cs_s;
      sclk_d_reg <= sclk_s;
      if (cs_fall) begin
        state_reg <= ST_OP;
        bit_cnt_reg <= 4'h0;
        byte_cnt_reg <= 3'h0;
        data_seen_reg <= 1'b0;
        quad_cmd_reg <= 1'b0;
      end else if (!cs_s && sclk_rise) begin
        sh_reg <= sh_next;
        bit_cnt_reg <= byte_end ? 4'h0 : cnt_next;
        if (byte_end && byte_cnt_reg != 3'h7) begin
          byte_cnt_reg <= byte_cnt_reg + 3'h1;
        end
        case (state_reg)
          ST_OP: begin
            if (byte_end) begin
              op_reg <= sh_next;
              if (sleep_any) begin
                state_reg <= (sh_next == `SFP_OP_WAKE ||
                  sh_next == `SFP_OP_SOFT_RESET) ? ST_DONE : ST_IGN;
              end else if (sh_next == `SFP_OP_SECREG_READ) begin
                state_reg <= ST_OUT;
                out_sh_reg <= secreg;
                out_first_reg <= 1'b1;
              end else if (busy_reg) begin
                state_reg <= ST_IGN;
              end else if (sh_next == `SFP_OP_PAGE_PROG ||
                  (sh_next == `SFP_OP_QUAD_PROG && !quad_command_mode_i)) begin
                state_reg <= ST_ADDR;
                quad_cmd_reg <= (sh_next == `SFP_OP_QUAD_PROG);
                mask_reg <= {256{1'b0}};
              end else if (sh_next == `SFP_OP_WRITE_ENABLE ||
                  sh_next == `SFP_OP_DEEP_SLEEP || sh_next == `SFP_OP_WAKE ||
                  sh_next == `SFP_OP_SOFT_RESET || sh_next == `SFP_OP_OTP_ENTER ||
                  sh_next == `SFP_OP_OTP_EXIT || sh_next == `SFP_OP_SECREG_WRITE) begin
                state_reg <= ST_DONE;
              end else begin
                state_reg <= ST_IGN;
              end
            end
          end
          ST_ADDR: begin
            if (byte_end) begin
              addr_reg <= {addr_reg[15:0], sh_next};
              if (byte_cnt_reg == `SFP_ADDR_BYTES) begin
                state_reg <= ST_DATA;
                ptr_reg <= sh_next;
              end
            end
          end
          ST_DATA: begin
            if (byte_end) begin
              mask_reg[ptr_reg] <= 1'b1;
              ptr_reg <= ptr_reg + 8'h01;
              data_seen_reg <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end else if (!cs_s && sclk_fall && state_reg == ST_OUT) begin
        out_first_reg <= 1'b0;
        if (!out_first_reg) begin
          out_sh_reg <= quad_command_mode_i ? {out_sh_reg[3:0], out_sh_reg[7:4]} :
            {out_sh_reg[6:0], out_sh_reg[7]};
        end
      end else if (cs_rise) begin
        state_reg <= ST_IGN;
        if (state_reg == ST_DONE && boundary) begin
          if (op_reg == `SFP_OP_WAKE || op_reg == `SFP_OP_SOFT_RESET) begin
            sleeping_reg <= 1'b0;
            sleep_pend_reg <= 1'b0;
            if (op_reg == `SFP_OP_SOFT_RESET && !busy_reg) begin
              latch_reg <= 1'b0;
              otp_mode_reg <= 1'b0;
            end
          end else if (op_only) begin
            if (op_reg == `SFP_OP_WRITE_ENABLE) begin
              latch_reg <= 1'b1;
            end else if (op_reg == `SFP_OP_DEEP_SLEEP) begin
              sleep_pend_reg <= 1'b1;
              sleep_cnt_reg <= SLEEP_CYC[15:0];
            end else if (op_reg == `SFP_OP_OTP_ENTER) begin
              otp_mode_reg <= 1'b1;
            end else if (op_reg == `SFP_OP_OTP_EXIT) begin
              otp_mode_reg <= 1'b0;
            end else if (op_reg == `SFP_OP_SECREG_WRITE && latch_reg) begin
              otp_lock_reg <= 1'b1;
              latch_reg <= 1'b0;
            end
          end
        end else if (state_reg == ST_DATA && data_seen_reg && boundary) begin
          if (latch_reg && (!quad_cmd_reg || quad_io_enable_i)) begin
            if (otp_mode_reg ? otp_locked : blk_prot) begin
              pfail_reg <= 1'b1;
              latch_reg <= 1'b0;
            end else begin
              busy_reg <= 1'b1;
              draining_reg <= 1'b1;
              drain_idx_reg <= 9'h000;
              prog_cnt_reg <= PROG_CYCLES;
              prog_otp_reg <= otp_mode_reg;
              page_base_reg <= otp_mode_reg ? {15'h0000, addr_reg[8]} :
                addr_reg[23:8];
            end
          end
        end
      end
      if (sleep_pend_reg && !(cs_rise && state_reg == ST_DONE)) begin
        if (sleep_cnt_reg == 16'h0000) begin
          sleep_pend_reg <= 1'b0;
          sleeping_reg <= 1'b1;
        end else begin
          sleep_cnt_reg <= sleep_cnt_reg - 16'h0001;
        end
      end
      if (drain_step) begin
        drain_idx_reg <= drain_idx_reg + 9'h001;
        if (drain_idx_reg == 9'h0FF) begin
          draining_reg <= 1'b0;
        end
      end
      if (busy_reg) begin
        if (prog_cnt_reg != 20'h00000) begin
          prog_cnt_reg <= prog_cnt_reg - 20'h00001;
        end else if (!draining_reg && !prog_valid_o) begin
          busy_reg <= 1'b0;
          latch_reg <= 1'b0;
          pfail_reg <= 1'b0;
        end
      end
    end
  end
endmodule // sfp_core
`default_nettype wire

// file: core/sfp_defines.vh
// Constants shared by the serial flash program and secure area controller.
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH

// Command byte values.
`define SFP_OP_WRITE_ENABLE 8'h06
`define SFP_OP_PAGE_PROG 8'h02
`define SFP_OP_QUAD_PROG 8'h38
`define SFP_OP_DEEP_SLEEP 8'hB9
`define SFP_OP_WAKE 8'hAB
`define SFP_OP_SOFT_RESET 8'h99
`define SFP_OP_OTP_ENTER 8'hB1
`define SFP_OP_OTP_EXIT 8'hC1
`define SFP_OP_SECREG_READ 8'h2B
`define SFP_OP_SECREG_WRITE 8'h2F

// Security register bit positions.
`define SFP_SEC_SCHEME 7
`define SFP_SEC_ERASE_FAIL 6
`define SFP_SEC_PROG_FAIL 5
`define SFP_SEC_ERASE_SUSP 3
`define SFP_SEC_PROG_SUSP 2
`define SFP_SEC_OTP_LOCK 1
`define SFP_SEC_FACTORY 0

// Sizes.
`define SFP_PAGE_BYTES 256
`define SFP_ADDR_BYTES 3'h3
`define SFP_FIFO_DEPTH 32
`define SFP_FIFO_WIDTH 33

// Timing.
`define SFP_CLK_PERIOD_NS 25
`define SFP_PROG_TIME_US 1000
`define SFP_SLEEP_DELAY_NS 10000

`endif

// file: core/sfp_sync.v
// Two flip-flop synchroniser for pin inputs.
`default_nettype none
module sfp_sync #(
  parameter W = 6,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire core_clk_i,
  input wire resetn_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_reg;

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= INIT;
      q_o <= INIT;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule // sfp_sync
`default_nettype wire

// file: core/sfp_fifo.v
// Synchronous FIFO with valid and ready on both sides.
`default_nettype none
module sfp_fifo #(
  parameter W = 33,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire core_clk_i,
  input wire resetn_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  assign in_ready_o = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // sfp_fifo
`default_nettype wire

// file: verif/sfp_core_monitor.sv
// Port checker of the program sequencer, bound to its top module.
`default_nettype none
module sfp_core_monitor #(
  parameter [19:0] PROG_CYCLES = 20'h9C40
) (
  input wire core_clk_i,
  input wire resetn_i,
  input wire cs_n_i,
  input wire quad_command_mode_i,
  input wire [3:0] sio_oe_o,
  input wire prog_valid_o,
  input wire prog_ready_i,
  input wire [23:0] prog_addr_o,
  input wire [7:0] prog_data_o,
  input wire write_latch_o,
  input wire write_in_progress_flag_o,
  input wire deep_sleep_o,
  input wire otp_lock_bit_o,
  input wire program_fail_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [19:0] busy_cnt;
  logic [8:0] high_cnt;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_cnt <= 20'h0;
      high_cnt <= 9'h0;
    end else begin
      busy_cnt <= write_in_progress_flag_o ? busy_cnt + 20'h1 : 20'h0;
      high_cnt <= cs_n_i ? high_cnt + {8'h0, high_cnt != 9'h1FF} : 9'h0;
    end
  end
  sequence s_stalled;
    prog_valid_o && !prog_ready_i;
  endsequence
  sequence s_word_held;
    prog_valid_o && $stable(prog_data_o) && $stable(prog_addr_o);
  endsequence
  a_start_latch: assert property (
    $rose(write_in_progress_flag_o) |-> write_latch_o && cs_n_i && $past(cs_n_i, 3))
    else $error("busy rose without latch");
  a_done_clear: assert property (
    $fell(write_in_progress_flag_o) |-> !write_latch_o && !program_fail_o
      && busy_cnt >= PROG_CYCLES - 20'h1) else $error("bad program end");
  a_word_hold: assert property (s_stalled |=> s_word_held) else $error("word lost");
  a_word_busy: assert property (prog_valid_o |-> write_in_progress_flag_o)
    else $error("word outside cycle");
  a_sleep_delay: assert property ($rose(deep_sleep_o) |-> high_cnt >= 9'h190)
    else $error("sleep too early");
  a_sleep_deaf: assert property ($rose(write_latch_o) |-> !$past(deep_sleep_o))
    else $error("latch set in sleep");
  a_fail_refuse: assert property (
    $rose(program_fail_o) |-> !write_in_progress_flag_o && !write_latch_o)
    else $error("fail with cycle or latch");
  a_read_drive: assert property (
    sio_oe_o != 4'h0 |-> !$past(cs_n_i, 4) && sio_oe_o == (quad_command_mode_i ? 4'hF : 4'h2))
    else $error("bad read drive");
  a_lock_stays: assert property (otp_lock_bit_o |=> otp_lock_bit_o)
    else $error("lock cleared");
endmodule // sfp_core_monitor
bind sfp_core sfp_core_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_mon (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i),
  .quad_command_mode_i(quad_command_mode_i), .sio_oe_o(sio_oe_o),
  .prog_valid_o(prog_valid_o), .prog_ready_i(prog_ready_i), .prog_addr_o(prog_addr_o),
  .prog_data_o(prog_data_o), .write_latch_o(write_latch_o),
  .write_in_progress_flag_o(write_in_progress_flag_o), .deep_sleep_o(deep_sleep_o),
  .otp_lock_bit_o(otp_lock_bit_o), .program_fail_o(program_fail_o));
`default_nettype wire

// file: verif/sfp_host_model.sv
// Host controller model driving select, serial clock and data lines.
`default_nettype none
module sfp_host_model (
  input wire logic core_clk_i,
  input wire logic [3:0] sio_i,
  output var logic cs_n_o,
  output var logic sclk_o,
  output var logic [3:0] sio_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sio_o = 4'h5;
  end
  task automatic sel();
    @(posedge core_clk_i);
    #3;
    cs_n_o = 1'b0;
    #100;
  endtask
  task automatic shift(input logic [31:0] v, input int n, input bit q);
    for (int i = n - 1; i >= 0; i -= (q ? 4 : 1)) begin
      sio_o = q ? v[i -: 4] : {~sio_o[3:1], v[i]};
      #100;
      sclk_o = 1'b1;
      #100;
      sclk_o = 1'b0;
    end
  endtask
  task automatic rd(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #100;
      sclk_o = 1'b1;
      b[i] = sio_i[1];
      #100;
      sclk_o = 1'b0;
    end
  endtask
  task automatic desel();
    #50;
    cs_n_o = 1'b1;
    sio_o = ~sio_o;
    #400;
  endtask
endmodule // sfp_host_model
`default_nettype wire

// file: verif/tb_top.sv
// Bench comparing the sequencer with a reference of its flags and stream.
`include "sfp_defines.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic quad_command_mode = 1'b0;
  logic qe = 1'b1;
  logic sch = 1'b0;
  logic stall = 1'b0;
  logic ready = 1'b0;
  logic [3:0] lpf = 4'h0;
  logic [3:0] sb = 4'h0;
  logic [255:0] pbl = 256'h0;
  logic [255:0] vbl = 256'h0;
  wire cs_n, sclk, pv, potp, wl, write_in_progress_flag, ds, om, lk, pf;
  wire [3:0] sio_h, sio_d, sio_oe, sio_w;
  wire [23:0] pa;
  wire [7:0] pd;
  bit m_wel, m_fail, m_otp, m_lock, m_slp;
  integer seed = 32'hFE2150F4;
  int err_count = 0;
  int n_compared = 0;
  logic [7:0] img [int];
  logic [32:0] got [$];
  sfp_core #(.PROG_CYCLES(20'h32)) i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .cs_n_i(cs_n), .sclk_i(sclk), .sio_i(sio_w), .sio_o(sio_d), .sio_oe_o(sio_oe),
    .quad_command_mode_i(quad_command_mode), .quad_io_enable_i(qe), .protect_scheme_select_i(sch),
    .legacy_protect_field_i(lpf), .persistent_block_lock_i(pbl), .volatile_block_lock_i(vbl),
    .factory_lock_i(sb[0]), .erase_fail_i(sb[1]), .erase_suspended_flag_i(sb[2]),
    .program_suspended_flag_i(sb[3]), .prog_valid_o(pv), .prog_ready_i(ready),
    .prog_otp_o(potp), .prog_addr_o(pa), .prog_data_o(pd), .write_latch_o(wl),
    .write_in_progress_flag_o(write_in_progress_flag), .deep_sleep_o(ds), .otp_mode_o(om),
    .otp_lock_bit_o(lk), .program_fail_o(pf));
  sfp_host_model i_host (.core_clk_i(core_clk_i), .sio_i(sio_w), .cs_n_o(cs_n),
    .sclk_o(sclk), .sio_o(sio_h));
  assign sio_w = (sio_oe & sio_d) | (~sio_oe & sio_h);
  always #12.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    #3;
    ready = !stall && $random(seed) % 4 != 0;
  end
  always @(posedge core_clk_i) begin
    if (pv && ready) got.push_back({potp, pa, pd});
  end
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic flags();
    chk({27'h0, wl, write_in_progress_flag, ds, om, lk, pf}, {27'h0, m_wel, 1'b0, m_slp, m_otp, m_lock, m_fail});
  endtask
  task automatic op(input logic [7:0] c, input int x);
    i_host.sel();
    i_host.shift({24'h0, c}, 8, quad_command_mode);
    if (x > 0) i_host.shift(32'h0, x, 1'b0);
    i_host.desel();
  endtask
  task automatic write_enable_cmd();
    op(`SFP_OP_WRITE_ENABLE, 0);
    if (!m_slp) m_wel = 1'b1;
  endtask
  task automatic nap(input int x);
    op(`SFP_OP_DEEP_SLEEP, x);
    repeat (450) @(posedge core_clk_i);
    #3;
    m_slp = x == 0;
    flags();
  endtask
  task automatic srd();
    logic [7:0] b;
    i_host.sel();
    i_host.shift({24'h0, `SFP_OP_SECREG_READ}, 8, quad_command_mode);
    repeat (2) begin
      i_host.rd(b);
      chk({25'h0, b}, {25'h0, sch, sb[1], m_fail, 1'b0, sb[2], sb[3], m_lock, sb[0]});
    end
    i_host.desel();
  endtask
  task automatic pp(input bit q, input logic [23:0] a, input int n, input int x);
    logic [7:0] d;
    bit pr;
    bit go;
    got.delete();
    img.delete();
    i_host.sel();
    i_host.shift({24'h0, q ? `SFP_OP_QUAD_PROG : `SFP_OP_PAGE_PROG}, 8, quad_command_mode);
    i_host.shift({8'h0, a}, 24, q | quad_command_mode);
    for (int k = 0; k < n; k++) begin
      d = $random(seed);
      i_host.shift({24'h0, d}, 8, q | quad_command_mode);
      img[(a[7:0] + k) % 256] = d;
    end
    if (x > 0) i_host.shift(32'h0, x, 1'b0);
    i_host.desel();
    if (n > 256) begin
      srd();
      stall = 1'b0;
    end
    pr = m_otp ? (m_lock | sb[0]) : (sch ? pbl[a[23:16]] | vbl[a[23:16]] : lpf > 4'h8);
    go = m_wel && !m_slp && x == 0 && (!q || qe) && !(q && quad_command_mode);
    repeat (3000) if (write_in_progress_flag) @(posedge core_clk_i) #3;
    if (!go || pr) img.delete();
    if (go) {m_wel, m_fail} = {1'b0, pr};
    for (int k = 0; k < 256; k++) begin
      if (img.exists(k)) begin
        chk(got.size() > 0 ? got.pop_front() : 33'h0,
          {m_otp, m_otp ? {15'h0, a[8], 8'(k)} : {a[23:8], 8'(k)}, img[k]});
      end
    end
    chk(33'(got.size()), 33'h0);
    flags();
  endtask
  initial begin
    #2ms;
    err_count++;
    end_sim();
  end
  initial begin
    sb = 4'($random(seed));
    repeat (16) @(posedge core_clk_i);
    #3;
    resetn_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #3;
    flags();
    pp(1'b0, 24'h123456, 1, 0);
    write_enable_cmd();
    pp(1'b0, 24'h1234FE, 4, 0);
    write_enable_cmd();
    pp(1'b0, 24'h2200A0, 2, 3);
    stall = 1'b1;
    pp(1'b0, 24'h3300C5, 258, 0);
    $display("test program finished");
    lpf = 4'h9;
    write_enable_cmd();
    pp(1'b0, 24'h440010, 1, 0);
    {lpf, sch} = {4'h0, 1'b1};
    vbl[8'h55] = 1'b1;
    write_enable_cmd();
    pp(1'b1, 24'h550020, 1, 0);
    qe = 1'b0;
    write_enable_cmd();
    pp(1'b1, 24'h660000, 2, 0);
    qe = 1'b1;
    pp(1'b1, 24'h660080, 3, 0);
    $display("test protect finished");
    quad_command_mode = 1'b1;
    write_enable_cmd();
    pp(1'b1, 24'h880000, 1, 0);
    pp(1'b0, 24'h880040, 2, 0);
    write_enable_cmd();
    flags();
    quad_command_mode = 1'b0;
    nap(3);
    nap(0);
    write_enable_cmd();
    pp(1'b0, 24'h770000, 1, 0);
    op(`SFP_OP_WAKE, 0);
    m_slp = 1'b0;
    flags();
    nap(0);
    op(`SFP_OP_SOFT_RESET, 0);
    {m_slp, m_wel, m_otp} = 3'h0;
    flags();
    $display("test sleep finished");
    op(`SFP_OP_OTP_ENTER, 0);
    m_otp = 1'b1;
    write_enable_cmd();
    pp(1'b0, 24'h000180, 2, 0);
    write_enable_cmd();
    op(`SFP_OP_SECREG_WRITE, 4);
    flags();
    op(`SFP_OP_SECREG_WRITE, 0);
    {m_lock, m_wel} = 2'h2;
    chk({32'h0, lk}, 33'h1);
    write_enable_cmd();
    pp(1'b0, 24'h000010, 1, 0);
    srd();
    op(`SFP_OP_OTP_EXIT, 0);
    m_otp = 1'b0;
    flags();
    $display("test otp finished");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
